// [prc_decode.sv]
// pulse-count rail configuration: shared package and pulse-code decoder
`default_nettype none

package prc_pkg;
	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ     = 25;
	localparam int STORE_NS    = 30000;   // line steady high to store code
	localparam int OFF_NS      = 30000;   // line low to shut rails down
	localparam int NEG_DLY_US  = 10000;   // negative rail start delay
	// least times round up to whole cycles
	localparam int STORE_CYC_I = (STORE_NS * CLK_MHZ + 999) / 1000;
	localparam int OFF_CYC_I   = (OFF_NS * CLK_MHZ + 999) / 1000;
	localparam int NEG_DLY_CYC = NEG_DLY_US * CLK_MHZ;
	localparam int HL_W        = 10;
	localparam int DLY_W       = 18;
	localparam logic [HL_W-1:0] STORE_CYC = HL_W'(STORE_CYC_I);
	localparam logic [HL_W-1:0] OFF_CYC   = HL_W'(OFF_CYC_I);
	localparam logic [HL_W-1:0] HL_ONE    = 10'h001;

	// ------------------------------------------------------------------
	// pulse codes
	// ------------------------------------------------------------------
	localparam logic [6:0] CNT_MAX  = 7'h7F;
	localparam logic [6:0] CNT_ONE  = 7'h01;
	localparam logic [6:0] NEG_LO   = 7'h01;
	localparam logic [6:0] NEG_HI   = 7'h33;
	localparam logic [6:0] ANA_LO   = 7'h34;
	localparam logic [6:0] ANA_HI   = 7'h4F;
	localparam logic [6:0] FD_ON    = 7'h50;
	localparam logic [6:0] FD_OFF   = 7'h51;
	localparam logic [6:0] DET_ON   = 7'h52;
	localparam logic [6:0] DET_OFF  = 7'h53;
	localparam logic [6:0] POS_LO   = 7'h54;
	localparam logic [6:0] POS_HI   = 7'h5A;
	localparam logic [6:0] OCPP_LO  = 7'h5B;
	localparam logic [6:0] OCPP_HI  = 7'h61;
	localparam logic [6:0] OCPA_LO  = 7'h62;
	localparam logic [6:0] OCPA_HI  = 7'h68;

	// ------------------------------------------------------------------
	// settings, held as index into each item's value list
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       det;      // 250mV detection on
		logic       fd_on;    // forced discharge value
		logic       fd_ovr;   // discharge forced by code
		logic [2:0] ocpa;     // analog-rail limit, 90mA + 30mA*idx
		logic [2:0] ocpp;     // positive-rail limit, 80mA + 95mA*idx
		logic [2:0] pos;      // positive rail, 4.6V + 0.1V*idx
		logic [4:0] ana;      // analog rail, 5.0V + 0.1V*idx
		logic [5:0] neg;      // negative rail, -6.4V + 0.1V*idx
	} prc_set_s;

	localparam prc_set_s SET_DEF = '{det: 1'b0, fd_on: 1'b0, fd_ovr: 1'b0,
		ocpa: 3'h4, ocpp: 3'h6, pos: 3'h0, ana: 5'h08, neg: 6'h18};

	typedef struct packed {
		logic       neg_v;
		logic       ana_v;
		logic       pos_v;
		logic       ocpp_v;
		logic       ocpa_v;
		logic       fd_v;
		logic       fd_on;
		logic       det_v;
		logic       det_on;
		logic [5:0] idx;
	} prc_upd_s;

	typedef struct packed {
		logic [6:0] count;
		logic       line_on;
		logic       pos_en;
		logic       neg_en;
		logic       ana_en;
		logic       dis;
	} prc_stat_s;

	// ------------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTL  = 8'h00;
	localparam logic [7:0] ADDR_SET  = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam int CTL_DEC_EN = 0;
	localparam int CTL_SOFT   = 1;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} prc_apb_s;

	typedef struct packed {
		logic             line_q;
		logic             line_on;
		logic [6:0]       count;
		logic [HL_W-1:0]  hi_cnt;
		logic [HL_W-1:0]  lo_cnt;
		logic [DLY_W-1:0] dly;
		prc_set_s         set;
		logic             pos_en;
		logic             neg_en;
		logic             ana_en;
		logic             dis;
		logic             dec_en;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} prc_st_s;

	localparam prc_st_s ST_DEF = '{line_q: 1'b0, line_on: 1'b0,
		count: 7'h00, hi_cnt: 10'h000, lo_cnt: 10'h000, dly: 18'h00000,
		set: SET_DEF, pos_en: 1'b0, neg_en: 1'b0, ana_en: 1'b0,
		dis: 1'b0, dec_en: 1'b1, pready: 1'b0, pslverr: 1'b0,
		prdata: 32'h00000000};

	// code falls inside an item's range
	function automatic logic prc_in(input logic [6:0] c,
		input logic [6:0] lo, input logic [6:0] hi);
		return (c >= lo) && (c <= hi);
	endfunction
endpackage

`timescale 1ns/100ps

// ----------------------------------------------------------------------
// code decoder
// ----------------------------------------------------------------------
module prc_code_decode (
	input  wire logic [6:0]        i_code,
	output var prc_pkg::prc_upd_s  o_upd
);
	// one item per code; anything outside the table yields no valid bit
	always_comb begin
		o_upd = '0;
		if (prc_pkg::prc_in(i_code, prc_pkg::NEG_LO, prc_pkg::NEG_HI)) begin
			o_upd.neg_v = 1'b1;
			o_upd.idx   = 6'(i_code - prc_pkg::NEG_LO);
		end else if (prc_pkg::prc_in(i_code, prc_pkg::ANA_LO,
			prc_pkg::ANA_HI)) begin
			o_upd.ana_v = 1'b1;
			o_upd.idx   = 6'(i_code - prc_pkg::ANA_LO);
		end else if (prc_pkg::prc_in(i_code, prc_pkg::POS_LO,
			prc_pkg::POS_HI)) begin
			o_upd.pos_v = 1'b1;
			o_upd.idx   = 6'(i_code - prc_pkg::POS_LO);
		end else if (prc_pkg::prc_in(i_code, prc_pkg::OCPP_LO,
			prc_pkg::OCPP_HI)) begin
			o_upd.ocpp_v = 1'b1;
			o_upd.idx    = 6'(i_code - prc_pkg::OCPP_LO);
		end else if (prc_pkg::prc_in(i_code, prc_pkg::OCPA_LO,
			prc_pkg::OCPA_HI)) begin
			o_upd.ocpa_v = 1'b1;
			o_upd.idx    = 6'(i_code - prc_pkg::OCPA_LO);
		end else if (i_code == prc_pkg::FD_ON || i_code == prc_pkg::FD_OFF) begin
			o_upd.fd_v  = 1'b1;
			o_upd.fd_on = (i_code == prc_pkg::FD_ON);
		end else if (i_code == prc_pkg::DET_ON ||
			i_code == prc_pkg::DET_OFF) begin
			o_upd.det_v  = 1'b1;
			o_upd.det_on = (i_code == prc_pkg::DET_ON);
		end
	end
endmodule // prc_code_decode

`default_nettype wire

// [prc_top.sv]
// pulse-count rail configuration and rail enable sequencing, apb slave
// Operation
// [RL1] count rising edges per train; final count selects one item value
// [RL2] codes 1..51 set negative rail -6.4V..-1.4V; default -4V
// [RL3] codes 52..79 analog rail, 84..90 positive rail, with defaults
// [RL4] codes 91..97 positive limit, 98..104 analog limit, with defaults
// [RL5] codes 80/81 force discharge on/off; 82/83 detection on/off
// [RL6] discharge pin high and no override: discharge outputs at shutdown
// [RL7] line high enables positive rail at its setting
// [RL8] negative rail enabled 10ms after line goes high
// [RL9] power cycle returns every setting to default
// [RL10] line held low for shutdown time restores both panel rail settings
// [RL11] analog pin switches analog rail; both low resets all settings
// [RL12] host holds line high 30..80us after last pulse to store
// [RL13] host keeps pulse phases 2..25us, one item per train
// [RL14] out-of-table counts are ignored, settings unchanged
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module prc_top #(
	parameter int unsigned NEG_DLY_CYC = prc_pkg::NEG_DLY_CYC
) (
	input  wire logic               i_core_clk,
	input  wire logic               i_resetn,
	input  wire logic               i_line,
	input  wire logic               i_analog_en,
	input  wire logic               i_discharge_select_pin,
	input  wire prc_pkg::prc_apb_s  i_apb,
	output var  prc_pkg::prc_set_s  o_set,
	output logic                    o_pos_rail_en,
	output logic                    o_neg_rail_en,
	output logic                    o_analog_rail_en,
	output logic                    o_fast_discharge,
	output logic [31:0]             o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr
);
	localparam logic [prc_pkg::DLY_W-1:0] DLY_TGT =
		NEG_DLY_CYC[prc_pkg::DLY_W-1:0];
	localparam logic [prc_pkg::DLY_W-1:0] DLY_ONE = 18'h00001;

	// ------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;

	// async assert, release after two edges
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------------
	// line events
	// ------------------------------------------------------------------
	prc_pkg::prc_st_s  st_r;
	prc_pkg::prc_st_s  st_nxt;
	prc_pkg::prc_upd_s upd;
	logic              rise;
	logic              store;
	logic              shut;
	logic              setup;
	logic              acc;
	logic              ctl_wr;
	logic              fd_eff;

	assign rise  = i_line && !st_r.line_q;
	// line steady high long enough after the last pulse: store the code
	assign store = i_line && st_r.line_on &&
		(st_r.hi_cnt == prc_pkg::STORE_CYC - prc_pkg::HL_ONE);         // [RL1]
	// low longer than any pulse gap: treat as shutdown
	assign shut  = !i_line && st_r.line_on &&
		(st_r.lo_cnt == prc_pkg::OFF_CYC - prc_pkg::HL_ONE);           // [RL10]
	assign setup  = i_apb.psel && !i_apb.penable;
	assign acc    = i_apb.psel && i_apb.penable && st_r.pready;
	assign ctl_wr = acc && i_apb.pwrite && (i_apb.paddr == prc_pkg::ADDR_CTL);

	prc_code_decode u_dec (
		.i_code (st_r.count),
		.o_upd  (upd)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt        = st_r;
		st_nxt.line_q = i_line;
		fd_eff        = 1'b0;

		// phase timers saturate so a long level never wraps
		if (i_line) begin
			st_nxt.lo_cnt = '0;
			if (st_r.hi_cnt != prc_pkg::STORE_CYC) begin
				st_nxt.hi_cnt = st_r.hi_cnt + prc_pkg::HL_ONE;
			end
		end else begin
			st_nxt.hi_cnt = '0;
			if (st_r.lo_cnt != prc_pkg::OFF_CYC) begin
				st_nxt.lo_cnt = st_r.lo_cnt + prc_pkg::HL_ONE;
			end
		end

		// enabling edge turns the positive rail on and is not counted as a pulse
		if (rise && !st_r.line_on) begin
			st_nxt.line_on = 1'b1;                                     // [RL7]
		end else if (rise && st_r.count != prc_pkg::CNT_MAX) begin
			st_nxt.count = st_r.count + prc_pkg::CNT_ONE;              // [RL1]
		end

		// store the train; codes outside the table touch nothing
		if (store) begin
			st_nxt.count = '0;                                         // [RL1]
			if (st_r.dec_en) begin
				if (upd.neg_v) st_nxt.set.neg = upd.idx;                 // [RL2]
				if (upd.ana_v) st_nxt.set.ana = upd.idx[4:0];            // [RL3]
				if (upd.pos_v) st_nxt.set.pos = upd.idx[2:0];            // [RL3]
				if (upd.ocpp_v) st_nxt.set.ocpp = upd.idx[2:0];          // [RL4]
				if (upd.ocpa_v) st_nxt.set.ocpa = upd.idx[2:0];          // [RL4]
				if (upd.fd_v) begin
					st_nxt.set.fd_ovr = 1'b1;                             // [RL5]
					st_nxt.set.fd_on  = upd.fd_on;
				end
				if (upd.det_v) st_nxt.set.det = upd.det_on;              // [RL5]
			end                                                        // [RL14]
		end

		// shutdown restores the panel rail settings only
		if (shut) begin
			st_nxt.line_on = 1'b0;
			st_nxt.count   = '0;
			st_nxt.set.neg = prc_pkg::SET_DEF.neg;                     // [RL10]
			st_nxt.set.pos = prc_pkg::SET_DEF.pos;                     // [RL10]
		end

		// both enables low: settings and count back to default
		if (!st_nxt.line_on && !i_analog_en) begin
			st_nxt.set   = prc_pkg::SET_DEF;                           // [RL11]
			st_nxt.count = '0;
		end

		// negative rail start delay, measured from line going on
		if (!st_r.line_on) begin
			st_nxt.dly = '0;
		end else if (st_r.dly != DLY_TGT) begin
			st_nxt.dly = st_r.dly + DLY_ONE;
		end
		st_nxt.pos_en = st_nxt.line_on;                                // [RL7]
		// old line_on too: a stale full count must not skip the delay
		st_nxt.neg_en = st_nxt.line_on && st_r.line_on &&
			(st_r.dly == DLY_TGT);                                     // [RL8]
		st_nxt.ana_en = i_analog_en;                                   // [RL11]

		// control register write; soft default comes last so it wins
		if (ctl_wr) begin
			st_nxt.dec_en = i_apb.pwdata[prc_pkg::CTL_DEC_EN];
			if (i_apb.pwdata[prc_pkg::CTL_SOFT]) begin
				st_nxt.set = prc_pkg::SET_DEF;
			end
		end

		// code override beats the pin; pin grounded leaves outputs floating
		fd_eff = st_nxt.set.fd_ovr ? st_nxt.set.fd_on
			: i_discharge_select_pin;                                  // [RL6]
		st_nxt.dis = fd_eff && (!st_nxt.line_on || !i_analog_en);     // [RL6]

		// no wait state: answer registered in setup, taken at the end of the first access cycle
		st_nxt.pready  = setup;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata  = '0;
		if (setup) begin
			case (i_apb.paddr)
				prc_pkg::ADDR_CTL:  st_nxt.prdata = 32'(st_r.dec_en);
				prc_pkg::ADDR_SET:  st_nxt.prdata = 32'(st_r.set);
				prc_pkg::ADDR_STAT: st_nxt.prdata = 32'(prc_pkg::prc_stat_s'(
					{st_r.count, st_r.line_on, st_r.pos_en, st_r.neg_en,
					st_r.ana_en, st_r.dis}));
				default:            st_nxt.pslverr = 1'b1;
			endcase
		end
	end

	// state register; power-on reset gives defaults everywhere
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= prc_pkg::ST_DEF;                                   // [RL9]
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign o_set            = st_r.set;
	assign o_pos_rail_en    = st_r.pos_en;
	assign o_neg_rail_en    = st_r.neg_en;
	assign o_analog_rail_en = st_r.ana_en;
	assign o_fast_discharge = st_r.dis;
	assign o_prdata         = st_r.prdata;
	assign o_pready         = st_r.pready;
	assign o_pslverr        = st_r.pslverr;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	chk_count_clear: assert property (store |=> st_r.count == '0) // [RL1]
		else $error("pulse count not cleared after store");
	chk_neg_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL2]
		prc_pkg::prc_in(st_r.count, prc_pkg::NEG_LO, prc_pkg::NEG_HI)
		|=> o_set.neg == 6'($past(st_r.count) - prc_pkg::NEG_LO))
		else $error("negative rail code not applied");
	chk_ana_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL3]
		prc_pkg::prc_in(st_r.count, prc_pkg::ANA_LO, prc_pkg::ANA_HI)
		|=> o_set.ana == 5'($past(st_r.count) - prc_pkg::ANA_LO))
		else $error("analog rail code not applied");
	chk_ocpa_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL4]
		prc_pkg::prc_in(st_r.count, prc_pkg::OCPA_LO, prc_pkg::OCPA_HI)
		|=> o_set.ocpa == 3'($past(st_r.count) - prc_pkg::OCPA_LO))
		else $error("analog limit code not applied");
	chk_fd_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL5]
		st_r.count == prc_pkg::FD_OFF |=> o_set.fd_ovr && !o_set.fd_on)
		else $error("discharge off code not applied");
	chk_discharge_gate: assert property (o_fast_discharge |-> // [RL6]
		(!o_pos_rail_en || !o_analog_rail_en) &&
		!(o_set.fd_ovr && !o_set.fd_on))
		else $error("discharge active while running or overridden off");
	chk_pos_on: assert property (rise && !st_r.line_on // [RL7]
		|=> o_pos_rail_en && !o_neg_rail_en)
		else $error("positive rail not enabled on line high");
	chk_neg_delay: assert property ($rose(o_neg_rail_en) |-> // [RL8]
		o_pos_rail_en && st_r.dly == DLY_TGT && $past(st_r.dly) != '0)
		else $error("negative rail enabled before its delay");
	chk_power_def: assert property ($rose(rst_sync_r[1]) |-> // [RL9]
		o_set == prc_pkg::SET_DEF)
		else $error("settings not default after reset");
	chk_off_default: assert property (shut |=> !o_pos_rail_en && // [RL10]
		o_set.neg == prc_pkg::SET_DEF.neg && o_set.pos == prc_pkg::SET_DEF.pos)
		else $error("panel rail settings kept over shutdown");
	chk_full_reset: assert property (!st_r.line_on && !i_analog_en // [RL11]
		|=> o_set == prc_pkg::SET_DEF && !o_analog_rail_en)
		else $error("settings kept with both enables low");
	chk_bad_code: assert property (store && !ctl_wr && // [RL14]
		st_r.count > prc_pkg::OCPA_HI |=> $stable(o_set))
		else $error("out-of-table count changed settings");

	// ------------------------------------------------------------------
	// further code and enable checks
	// ------------------------------------------------------------------
	// the remaining items, one check each
	chk_pos_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL3]
		prc_pkg::prc_in(st_r.count, prc_pkg::POS_LO, prc_pkg::POS_HI)
		|=> o_set.pos == 3'($past(st_r.count) - prc_pkg::POS_LO))
		else $error("positive rail code not applied");
	chk_ocpp_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL4]
		prc_pkg::prc_in(st_r.count, prc_pkg::OCPP_LO, prc_pkg::OCPP_HI)
		|=> o_set.ocpp == 3'($past(st_r.count) - prc_pkg::OCPP_LO))
		else $error("positive limit code not applied");
	chk_fd_on_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL5]
		st_r.count == prc_pkg::FD_ON |=> o_set.fd_ovr && o_set.fd_on)
		else $error("discharge on code not applied");
	chk_det_code: assert property (store && st_r.dec_en && !ctl_wr && // [RL5]
		(st_r.count == prc_pkg::DET_ON || st_r.count == prc_pkg::DET_OFF)
		|=> o_set.det == ($past(st_r.count) == prc_pkg::DET_ON))
		else $error("detection code not applied");
	// decoding off: a stored train must leave every setting alone
	chk_decode_off: assert property (store && !st_r.dec_en && !ctl_wr // [RL14]
		|=> $stable(o_set))
		else $error("settings changed with decoding off");
	// enabling rise is not a pulse; later rises count one each until the count reaches CNT_MAX
	chk_enable_uncounted: assert property (rise && !st_r.line_on // [RL1]
		|=> st_r.count == $past(st_r.count))
		else $error("enabling edge counted as a pulse");
	chk_count_step: assert property (rise && st_r.line_on && // [RL1]
		st_r.count != prc_pkg::CNT_MAX
		|=> st_r.count == $past(st_r.count) + prc_pkg::CNT_ONE)
		else $error("pulse edge not counted");
	chk_analog_kept: assert property (shut && i_analog_en && !ctl_wr // [RL10]
		|=> o_set.ana == $past(o_set.ana))
		else $error("analog setting lost at panel shutdown");
	chk_shut_discharge: assert property (shut && i_analog_en && !ctl_wr // [RL6]
		|=> o_fast_discharge == ($past(o_set.fd_ovr) ? $past(o_set.fd_on)
		: $past(i_discharge_select_pin)))
		else $error("shutdown discharge does not follow pin or code");
	chk_analog_follow: assert property ($changed(i_analog_en) // [RL11]
		|=> o_analog_rail_en == $past(i_analog_en))
		else $error("analog rail does not follow its pin");

	// main scenarios reached
	cov_neg_store: cover property (store && upd.neg_v);
	cov_code_ignored: cover property (store && st_r.count > prc_pkg::OCPA_HI);
	cov_neg_on: cover property ($rose(o_neg_rail_en));
	cov_shutdown: cover property (shut ##1 o_fast_discharge);
	cov_apb_read: cover property (acc && !i_apb.pwrite && !o_pslverr);
endmodule // prc_top

`default_nettype wire

// [prc_host_model.sv]
// host model that drives the pulse-count configuration line
`timescale 1ns/100ps
`default_nettype none

module prc_host_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_start,
	input  wire logic [1:0] i_op,
	input  wire logic [6:0] i_code,
	input  wire logic [9:0] i_phase,
	output logic            o_line,
	output logic            o_busy
);
	// ------------------------------------------------------------------
	// line sequencer: op 0 pulse train, 1 hold high, 2 hold low
	// ------------------------------------------------------------------
	localparam int HOLD = 780;  // 31.2us, low end of the storage window
	initial begin
		o_line = 1'b0;
		o_busy = 1'b0;
	end
	// one request at a time; line stays put between requests
	always @(posedge i_core_clk) begin
		if (i_start && !o_busy) begin
			o_busy <= 1'b1;
			if (i_op == 2'h0) begin
				for (int p = 0; p < int'(i_code); p++) begin
					o_line <= 1'b0;
					repeat (i_phase) @(posedge i_core_clk);
					o_line <= 1'b1;
					// last pulse stays high long enough to store
					repeat (p == int'(i_code) - 1 ? HOLD : int'(i_phase))
						@(posedge i_core_clk);
				end
			end else begin
				o_line <= (i_op == 2'h1);
				repeat (HOLD + 20) @(posedge i_core_clk);
			end
			o_busy <= 1'b0;
		end
	end
endmodule // prc_host_model
`default_nettype wire

// [pulse_count_rail_config_test.sv]
// self-checking bench for the pulse-count rail configuration block
`timescale 1ns/100ps
`default_nettype none

module pulse_count_rail_config_test;
	localparam int NEG = 50;  // shortened negative rail delay
	typedef struct {
		logic [6:0] code;
		int         sel;
		logic [5:0] idx;
		logic [9:0] ph;
	} prc_row_s;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic               clk = 1'b0;
	logic               rstn = 1'b0;
	logic               ana_en = 1'b1;
	logic               fd_pin = 1'b1;
	logic               start = 1'b0;
	logic [1:0]         op = 2'h0;
	logic [6:0]         code = 7'h00;
	logic [9:0]         ph = 10'h032;
	prc_pkg::prc_apb_s  apb = '0;
	prc_pkg::prc_set_s  set;
	prc_pkg::prc_set_s  exp;
	logic               line, busy, pos_en, neg_en, ana_out, fast;
	logic [31:0]        prdata;
	logic               pready, pslverr;
	int                 fail_count = 0;
	int                 comparisons = 0;
	// sel: 0 neg, 1 ana, 2 pos, 3 ocpp, 4 ocpa, 5 fd, 6 det, 7 ignored
	prc_row_s rows [11] = '{'{7'h01, 0, 6'h00, 10'h258},
		'{7'h33, 0, 6'h32, 10'h032}, '{7'h4F, 1, 6'h1B, 10'h032},
		'{7'h55, 2, 6'h01, 10'h032}, '{7'h5B, 3, 6'h00, 10'h032},
		'{7'h62, 4, 6'h00, 10'h032}, '{7'h50, 5, 6'h01, 10'h032},
		'{7'h51, 5, 6'h00, 10'h032}, '{7'h52, 6, 6'h01, 10'h032},
		'{7'h53, 6, 6'h00, 10'h032}, '{7'h69, 7, 6'h00, 10'h032}};

	always #20 clk = ~clk;  // 25 MHz

	prc_host_model u_host (.i_core_clk(clk), .i_start(start), .i_op(op),
		.i_code(code), .i_phase(ph), .o_line(line), .o_busy(busy));

	prc_top #(.NEG_DLY_CYC(NEG)) u_dut (.i_core_clk(clk), .i_resetn(rstn),
		.i_line(line), .i_analog_en(ana_en), .i_discharge_select_pin(fd_pin),
		.i_apb(apb), .o_set(set), .o_pos_rail_en(pos_en),
		.o_neg_rail_en(neg_en), .o_analog_rail_en(ana_out),
		.o_fast_discharge(fast), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic report_and_stop();
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// bounded wait for the host model to finish its request
	task automatic wait_idle();
		int k;
		for (k = 0; k < 20000 && busy !== 1'b0; k++)
			@(posedge clk);
		if (busy !== 1'b0) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	task automatic host(input logic [1:0] o, input logic [6:0] c,
		input logic [9:0] p);
		@(posedge clk);
		start <= 1'b1;
		op <= o;
		code <= c;
		ph <= p;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);  // let the model raise busy first
		wait_idle();
	endtask

	// line rises: positive rail at once, negative rail NEG+1 cycles later
	task automatic enable_line();
		int k;
		int np;
		int nn;
		np = -1;
		nn = -1;
		@(posedge clk);
		start <= 1'b1;
		op <= 2'h1;
		@(posedge clk);
		start <= 1'b0;
		for (k = 0; k < 2000 && nn < 0; k++) begin
			@(posedge clk);
			if (pos_en === 1'b1 && np < 0)
				np = k;
			if (neg_en === 1'b1)
				nn = k;
		end
		chk("pos_rail_start", 32'h1, np >= 0 && np <= 6);
		chk("neg_rail_delay", 32'h1, nn - np >= NEG && nn - np <= NEG + 3);
		wait_idle();
	endtask

	// apb master: setup, access held until pready sampled high
	task automatic apb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int k;
		@(posedge clk);
		apb.psel <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite <= w;
		apb.paddr <= a;
		apb.pwdata <= wd;
		@(posedge clk);
		apb.penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		if (k == 50) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic        err;
		exp = prc_pkg::SET_DEF;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk("set_after_reset", {9'h0, exp}, {9'h0, set});
		apb_xfer(1'b0, prc_pkg::ADDR_CTL, 32'h0, rd, err);
		chk("ctl_reset", 32'h1, rd);
		apb_xfer(1'b0, 8'h0C, 32'h0, rd, err);
		chk("unmapped_err", 32'h1, {31'h0, err});
		enable_line();
		// one code per train, whole settings word compared each time
		foreach (rows[i]) begin
			host(2'h0, rows[i].code, rows[i].ph);
			case (rows[i].sel)
				0: exp.neg = rows[i].idx;
				1: exp.ana = rows[i].idx[4:0];
				2: exp.pos = rows[i].idx[2:0];
				3: exp.ocpp = rows[i].idx[2:0];
				4: exp.ocpa = rows[i].idx[2:0];
				5: begin
					exp.fd_ovr = 1'b1;
					exp.fd_on = rows[i].idx[0];
				end
				6: exp.det = rows[i].idx[0];
				default: ;
			endcase
			chk("set_row", {9'h0, exp}, {9'h0, set});
		end
		apb_xfer(1'b0, prc_pkg::ADDR_SET, 32'h0, rd, err);
		chk("set_reg", {9'h0, exp}, rd);
		// shutdown keeps the other items, override off beats the pin
		host(2'h2, 7'h00, 10'h032);
		exp.neg = 6'h18;
		exp.pos = 3'h0;
		chk("shutdown_rails", 32'h0, {30'h0, pos_en, neg_en});
		chk("shutdown_set", {9'h0, exp}, {9'h0, set});
		chk("fd_forced_off", 32'h0, {31'h0, fast});
		@(posedge clk);
		ana_en <= 1'b0;
		repeat (3) @(posedge clk);
		chk("full_default", {9'h0, prc_pkg::SET_DEF}, {9'h0, set});
		chk("analog_off", 32'h0, {31'h0, ana_out});
		chk("fd_pin_high", 32'h1, {31'h0, fast});
		fd_pin <= 1'b0;
		repeat (2) @(posedge clk);
		chk("fd_pin_low", 32'h0, {31'h0, fast});
		ana_en <= 1'b1;
		enable_line();
		host(2'h0, 7'h02, 10'h032);
		exp = prc_pkg::SET_DEF;
		exp.neg = 6'h01;
		chk("set_again", {9'h0, exp}, {9'h0, set});
		apb_xfer(1'b1, prc_pkg::ADDR_CTL, 32'h3, rd, err);
		repeat (2) @(posedge clk);
		chk("soft_default", {9'h0, prc_pkg::SET_DEF}, {9'h0, set});
		host(2'h0, 7'h03, 10'h032);
		exp.neg = 6'h02;
		chk("set_after_soft", {9'h0, exp}, {9'h0, set});
		// decoding switched off: train counted, nothing applied
		apb_xfer(1'b1, prc_pkg::ADDR_CTL, 32'h0, rd, err);
		host(2'h0, 7'h01, 10'h032);
		chk("decode_off_set", {9'h0, exp}, {9'h0, set});
		apb_xfer(1'b0, prc_pkg::ADDR_STAT, 32'h0, rd, err);
		chk("stat_rails_on", 32'h0000001E, rd);
		// power cycle in mid-run
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("power_cycle", {9'h0, prc_pkg::SET_DEF}, {9'h0, set});
		chk("power_cycle_pos", 32'h0, {31'h0, pos_en});
		report_and_stop();
	end
endmodule // pulse_count_rail_config_test
`default_nettype wire
